// ==== design/fsb_mem.sv ====
`timescale 1ns/1ps
`include "fsb_params.svh"

module fsb_mem
   import fsb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   fsb_mem_if.mem port
);

   // One array per byte lane so each lane has a single writer
   for (genvar g = 0; g < `FSB_LANES; g++) begin : g_lane
      fsb_lane_t arr [0:`FSB_DEPTH-1];
      fsb_lane_t rd_r;
      fsb_lane_t rd_nxt;

      // Read sees the old word when a late write hits the same address
      always_comb begin
         rd_nxt = port.rd_en ? arr[port.rd_addr] : rd_r;
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rd_r <= `FSB_LANE_RST;
         end else begin
            rd_r <= rd_nxt;
         end
      end

      always_ff @(posedge clk) begin
         if (port.wr_en && port.wr_be[g]) begin
            arr[port.wr_addr] <= port.wr_data[g*`FSB_LANE_W +: `FSB_LANE_W];
         end
      end

      assign port.rd_data[g*`FSB_LANE_W +: `FSB_LANE_W] = rd_r;
   end

endmodule : fsb_mem

// ==== design/fsb_mem_if.sv ====
`timescale 1ns/1ps

interface fsb_mem_if;
   import fsb_pkg::*;
   logic rd_en;
   fsb_addr_t rd_addr;
   logic wr_en;
   fsb_addr_t wr_addr;
   fsb_be_t wr_be;
   fsb_word_t wr_data;
   fsb_word_t rd_data;

   modport ctl (
      output rd_en,
      output rd_addr,
      output wr_en,
      output wr_addr,
      output wr_be,
      output wr_data,
      input rd_data
   );

   modport mem (
      input rd_en,
      input rd_addr,
      input wr_en,
      input wr_addr,
      input wr_be,
      input wr_data,
      output rd_data
   );
endinterface : fsb_mem_if

// ==== design/fsb_params.svh ====
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH

`define FSB_ADDR_W 20
`define FSB_LANE_W 9
`define FSB_LANES 2
`define FSB_WORD_W 18
`define FSB_DEPTH 1048576
`define FSB_LO_W 2
`define FSB_CNT_RST 2'h0
`define FSB_CNT_STEP 2'h1
`define FSB_ADDR_RST 20'h00000
`define FSB_BE_RST 2'h0
`define FSB_BE_NONE 2'h0
`define FSB_LANE_RST 9'h000

`endif

// ==== design/fsb_pkg.sv ====
`include "fsb_params.svh"

package fsb_pkg;

   typedef logic [`FSB_ADDR_W-1:0] fsb_addr_t;
   typedef logic [`FSB_LANE_W-1:0] fsb_lane_t;
   typedef logic [`FSB_WORD_W-1:0] fsb_word_t;
   typedef logic [`FSB_LANES-1:0] fsb_be_t;
   typedef logic [`FSB_LO_W-1:0] fsb_cnt_t;

   typedef enum logic [1:0] {
      FSB_ST_DESEL,
      FSB_ST_READ,
      FSB_ST_WRITE
   } fsb_state_t;

endpackage : fsb_pkg

// ==== design/fsb_sram.sv ====
// Contract
// - Sleep high: device deselected in snooze; stays deselected after release until the next load.
// - In snooze all inputs but sleep ignored, data outputs high impedance.
// - Order select high: low address bits are start XOR beat count.
// - Order select low: low address bits count up modulo four.
// - Two-bit burst counter wraps to the start after every fourth beat.
// - Selected read load with output enable low drives the addressed word.
// - Output enable high on a read beat: dummy read, pins stay floating.
// - Selected write load with any byte enable low starts a write burst.
// - All byte enables high on a write beat: abort, store nothing.
// - Each byte enable gates only its own data lane, every write beat.
// - Advance high continues the burst type fixed by the load cycle.
// - Burst counter advances on every read or write continue cycle, not on continue-deselect.
// - Continue-deselect only follows deselect; pins stay floating.
// - Clock hold high freezes all state, no write, bus state kept.
// - Output drivers turn off during write cycles automatically.
// - Data outputs float during power-up before any cycle.
// - Write data arrives one cycle after its command, address, enables.
// - Any chip select inactive on a load deselects and floats outputs.
// - Advance high ignores address, selects, direction; steps by order.
`timescale 1ns/1ps
`include "fsb_params.svh"

module fsb_sram
   import fsb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`FSB_ADDR_W-3:0] address_upper,
   input wire logic address_bit_one,
   input wire logic address_bit_zero,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic advance_or_load,
   input wire logic read_not_write,
   input wire logic byte_write_lower_n,
   input wire logic byte_write_upper_n,
   input wire logic output_enable_n,
   input wire logic clock_hold_n,
   input wire logic burst_order_select_n,
   input wire logic sleep_request,
   input wire logic [`FSB_LANE_W-1:0] data_lane_lower_in,
   input wire logic [`FSB_LANE_W-1:0] data_lane_upper_in,
   output logic [`FSB_LANE_W-1:0] data_lane_lower_out,
   output logic [`FSB_LANE_W-1:0] data_lane_upper_out,
   output logic data_lane_lower_oe,
   output logic data_lane_upper_oe
);

   fsb_mem_if m ();

   fsb_mem u_mem (
      .clk (clk),
      .rstn (rstn),
      .port (m.mem)
   );

   fsb_state_t state_r;
   fsb_state_t state_nxt;
   fsb_addr_t base_r;
   fsb_addr_t base_nxt;
   fsb_cnt_t cnt_r;
   fsb_cnt_t cnt_nxt;
   logic rd_act_r;
   logic rd_act_nxt;
   logic pend_r;
   logic pend_nxt;
   fsb_addr_t wa_r;
   fsb_addr_t wa_nxt;
   fsb_be_t wbe_r;
   fsb_be_t wbe_nxt;

   fsb_addr_t ext_addr;
   fsb_addr_t next_addr;
   fsb_cnt_t step;
   fsb_cnt_t beat_lo;
   fsb_be_t be_now;
   logic sel;
   logic load;
   logic go;
   logic drive;

   assign ext_addr = {address_upper, address_bit_one, address_bit_zero};
   assign be_now = {~byte_write_upper_n, ~byte_write_lower_n};
   assign sel = ~chip_select_first_n & chip_select_second
                & ~chip_select_third_n;
   assign load = ~advance_or_load;
   assign go = ~sleep_request & ~clock_hold_n;

   // Only the low two bits move, so a burst never leaves its aligned quad
   assign step = cnt_r + `FSB_CNT_STEP;
   always_comb begin
      if (burst_order_select_n) begin
         beat_lo = base_r[`FSB_LO_W-1:0] ^ step;
      end else begin
         beat_lo = base_r[`FSB_LO_W-1:0] + step;
      end
   end
   assign next_addr = {base_r[`FSB_ADDR_W-1:`FSB_LO_W], beat_lo};

   always_comb begin
      state_nxt = state_r;
      base_nxt = base_r;
      cnt_nxt = cnt_r;
      rd_act_nxt = rd_act_r;
      pend_nxt = pend_r;
      wa_nxt = wa_r;
      wbe_nxt = wbe_r;
      m.rd_en = 1'h0;
      m.rd_addr = next_addr;
      m.wr_en = 1'h0;
      if (sleep_request) begin
         // Pending work is dropped; the controller must drain first
         state_nxt = FSB_ST_DESEL;
         rd_act_nxt = 1'h0;
         pend_nxt = 1'h0;
      end else if (clock_hold_n) begin
         // Wait state: every register keeps its value, no array write
         state_nxt = state_r;
      end else begin
         // Late write: this edge takes the data of the previous beat
         m.wr_en = pend_r;
         pend_nxt = 1'h0;
         rd_act_nxt = 1'h0;
         if (load) begin
            if (!sel) begin
               state_nxt = FSB_ST_DESEL;
            end else begin
               base_nxt = ext_addr;
               cnt_nxt = `FSB_CNT_RST;
               if (read_not_write) begin
                  state_nxt = FSB_ST_READ;
                  m.rd_en = 1'h1;
                  m.rd_addr = ext_addr;
                  rd_act_nxt = 1'h1;
               end else begin
                  state_nxt = FSB_ST_WRITE;
                  pend_nxt = |be_now;
                  wa_nxt = ext_addr;
                  wbe_nxt = be_now;
               end
            end
         end else begin
            // Address, selects and direction are not looked at here
            unique case (state_r)
               FSB_ST_DESEL: begin
                  state_nxt = FSB_ST_DESEL;
               end
               FSB_ST_READ: begin
                  cnt_nxt = step;
                  m.rd_en = 1'h1;
                  m.rd_addr = next_addr;
                  rd_act_nxt = 1'h1;
               end
               FSB_ST_WRITE: begin
                  cnt_nxt = step;
                  pend_nxt = |be_now;
                  wa_nxt = next_addr;
                  wbe_nxt = be_now;
               end
               default: begin
                  state_nxt = FSB_ST_DESEL;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= FSB_ST_DESEL;
         base_r <= `FSB_ADDR_RST;
         cnt_r <= `FSB_CNT_RST;
         rd_act_r <= 1'h0;
         pend_r <= 1'h0;
         wa_r <= `FSB_ADDR_RST;
         wbe_r <= `FSB_BE_RST;
      end else begin
         state_r <= state_nxt;
         base_r <= base_nxt;
         cnt_r <= cnt_nxt;
         rd_act_r <= rd_act_nxt;
         pend_r <= pend_nxt;
         wa_r <= wa_nxt;
         wbe_r <= wbe_nxt;
      end
   end

   assign m.wr_addr = wa_r;
   assign m.wr_be = wbe_r;
   assign m.wr_data = {data_lane_upper_in, data_lane_lower_in};

   // Output enable and sleep gate the drivers without waiting for a clock
   assign drive = rd_act_r & ~output_enable_n & ~sleep_request;
   assign data_lane_lower_oe = drive;
   assign data_lane_upper_oe = drive;
   assign data_lane_lower_out = m.rd_data[`FSB_LANE_W-1:0];
   assign data_lane_upper_out = m.rd_data[`FSB_WORD_W-1:`FSB_LANE_W];

   default clocking fsb_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence load_rd_s;
      go && load && sel && read_not_write;
   endsequence

   sequence load_wr_s;
      go && load && sel && !read_not_write;
   endsequence

   sequence cont_s;
      go && advance_or_load;
   endsequence

   sequence cont_rd_s;
      go && advance_or_load && state_r == FSB_ST_READ;
   endsequence

   sequence cont_wr_s;
      go && advance_or_load && state_r == FSB_ST_WRITE;
   endsequence

   sleep_hiz_a: assert property (
      sleep_request |-> !data_lane_lower_oe && !data_lane_upper_oe)
      else $error("outputs driven in snooze");

   sleep_desel_a: assert property (
      sleep_request |=> state_r == FSB_ST_DESEL && !pend_r && !rd_act_r)
      else $error("snooze did not deselect");

   interleave_a: assert property (
      load_rd_s ##1 (cont_s and burst_order_select_n)
      |-> m.rd_en && m.rd_addr[1:0] ==
          ($past({address_bit_one, address_bit_zero}) ^ 2'h1))
      else $error("interleaved step wrong");

   linear_a: assert property (
      load_rd_s ##1 (cont_s and !burst_order_select_n)
      ##1 (cont_s and !burst_order_select_n)
      |-> m.rd_addr[1:0] ==
          $past({address_bit_one, address_bit_zero}, 2) + 2'h2)
      else $error("linear step wrong");

   wrap_a: assert property (
      load_rd_s ##1 cont_s [*4]
      |-> m.rd_addr == $past(ext_addr, 4))
      else $error("burst did not wrap to start");

   read_drive_a: assert property (
      load_rd_s ##1 (!output_enable_n && !sleep_request)
      |-> data_lane_lower_oe && data_lane_upper_oe)
      else $error("read not driven");

   dummy_hiz_a: assert property (
      output_enable_n
      |-> !data_lane_lower_oe && !data_lane_upper_oe)
      else $error("driven with output enable high");

   write_abort_a: assert property (
      (load_wr_s and (be_now == `FSB_BE_NONE)) ##1 go
      |-> !m.wr_en)
      else $error("aborted write stored");

   late_write_a: assert property (
      (load_wr_s and !byte_write_lower_n and byte_write_upper_n) ##1 go
      |-> m.wr_en && m.wr_be == 2'h1
          && m.wr_addr == $past(ext_addr))
      else $error("late write wrong");

   hold_freeze_a: assert property (
      (!sleep_request && clock_hold_n)
      |-> !m.wr_en ##1 ($stable(state_r) && $stable(cnt_r)
                        && $stable(rd_act_r)))
      else $error("hold did not freeze");

   write_hiz_a: assert property (
      load_wr_s |=> !data_lane_lower_oe && !data_lane_upper_oe)
      else $error("driven during write");

   cont_desel_a: assert property (
      (go && load && !sel) ##1 cont_s
      |=> state_r == FSB_ST_DESEL && !data_lane_lower_oe)
      else $error("continue deselect drove bus");

   advance_a: assert property (
      (cont_s and state_r != FSB_ST_DESEL)
      |=> cnt_r == $past(cnt_r) + 2'h1)
      else $error("counter did not advance");

   read_addr_a: assert property (
      load_rd_s
      |-> m.rd_en && m.rd_addr == ext_addr)
      else $error("read load used wrong address");

   desel_float_a: assert property (
      (go && load && !sel)
      |=> !data_lane_lower_oe && !data_lane_upper_oe)
      else $error("deselect drove bus");

   write_load_a: assert property (
      load_wr_s
      |=> state_r == FSB_ST_WRITE && wa_r == $past(ext_addr)
          && pend_r == $past(|be_now))
      else $error("write load not taken");

   cont_read_a: assert property (
      cont_rd_s
      |-> m.rd_en ##1 state_r == FSB_ST_READ)
      else $error("read burst not continued");

   cont_write_a: assert property (
      cont_wr_s
      |-> !m.rd_en ##1 state_r == FSB_ST_WRITE)
      else $error("write burst not continued");

   lane_gate_a: assert property (
      cont_wr_s
      |=> wbe_r == $past(be_now)
          && pend_r == $past(|be_now))
      else $error("byte enables not taken per beat");

   cont_ignore_a: assert property (
      (cont_rd_s or cont_wr_s)
      |=> $stable(base_r))
      else $error("continue took external address");

   desel_stay_a: assert property (
      (go && advance_or_load && state_r == FSB_ST_DESEL)
      |=> state_r == FSB_ST_DESEL && !rd_act_r)
      else $error("continue deselect left deselect");

   sleep_idle_a: assert property (
      sleep_request |-> !m.wr_en && !m.rd_en)
      else $error("array used in snooze");

   read_active_a: assert property (
      load_rd_s
      |=> rd_act_r && cnt_r == `FSB_CNT_RST)
      else $error("read beat not presented");

   write_state_a: assert property (
      state_r == FSB_ST_WRITE
      |-> !data_lane_lower_oe && !data_lane_upper_oe)
      else $error("driven in write burst");

   lanes_same_a: assert property (
      data_lane_lower_oe == data_lane_upper_oe)
      else $error("lane drivers differ");

endmodule : fsb_sram

// ==== tb/fsb_ctl_model.sv ====
`timescale 1ns/1ps
`include "fsb_params.svh"

module fsb_ctl_model
   import fsb_pkg::*;
(
   input wire logic clk,
   output logic [`FSB_ADDR_W-3:0] address_upper,
   output logic address_bit_one,
   output logic address_bit_zero,
   output logic chip_select_first_n,
   output logic chip_select_second,
   output logic chip_select_third_n,
   output logic advance_or_load,
   output logic read_not_write,
   output logic byte_write_lower_n,
   output logic byte_write_upper_n,
   output logic output_enable_n,
   output logic clock_hold_n,
   output logic burst_order_select_n,
   output logic sleep_request,
   output fsb_word_t drv,
   input wire fsb_word_t q,
   input wire logic [1:0] q_oe
);
   fsb_word_t q_r;
   logic [1:0] qoe_r;

   initial begin
      {address_upper, address_bit_one, address_bit_zero} = 20'h00000;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h7;
      {advance_or_load, read_not_write, output_enable_n} = 3'h2;
      {byte_write_upper_n, byte_write_lower_n} = 2'h3;
      {clock_hold_n, sleep_request, burst_order_select_n} = 3'h1;
      drv = 18'h00000;
   end

   // One bus cycle; outputs of the last edge are captured first
   task automatic go(input logic [10:0] c, input fsb_addr_t a,
         input fsb_word_t d);
      @(negedge clk); // Inputs settle far from the edge
      q_r = q;
      qoe_r = q_oe;
      {address_upper, address_bit_one, address_bit_zero} = a;
      chip_select_first_n = (c[8:7] == 2'h1);
      chip_select_second = (c[8:7] != 2'h2);
      chip_select_third_n = (c[8:7] == 2'h3);
      sleep_request = c[6];
      clock_hold_n = c[5];
      output_enable_n = c[4];
      advance_or_load = c[3];
      read_not_write = c[2];
      byte_write_upper_n = c[1];
      byte_write_lower_n = c[0];
      burst_order_select_n = ~c[9];
      // Released bus toggles so stale data never looks valid
      drv = c[10] ? d : ~drv;
   endtask : go
endmodule : fsb_ctl_model

// ==== tb/test_fsb_sram.sv ====
`timescale 1ns/1ps
`include "fsb_params.svh"

module test_fsb_sram
   import fsb_pkg::*;
   ;
   localparam logic [10:0] WR = 11'h000, RD = 11'h007, AD = 11'h008;
   localparam logic [10:0] DS = 11'h087, DV = 11'h400, LIN = 11'h200;
   localparam logic [10:0] OEH = 11'h010, HLD = 11'h020, SLP = 11'h040;
   logic clk, rstn;
   logic [`FSB_ADDR_W-3:0] address_upper;
   logic address_bit_one, address_bit_zero, chip_select_first_n;
   logic chip_select_second, chip_select_third_n, advance_or_load;
   logic read_not_write, byte_write_lower_n, byte_write_upper_n;
   logic output_enable_n, clock_hold_n, burst_order_select_n;
   logic sleep_request, data_lane_lower_oe, data_lane_upper_oe;
   logic [`FSB_LANE_W-1:0] data_lane_lower_in, data_lane_upper_in;
   logic [`FSB_LANE_W-1:0] data_lane_lower_out, data_lane_upper_out;
   fsb_word_t drv, q, e12, e13;
   logic [1:0] q_oe;
   int fails = 0;
   int total_checks = 0;
   fsb_word_t dw [4] = '{18'h1A5C3, 18'h2B6D4, 18'h0C7E5, 18'h3D8F6};
   fsb_word_t nw [2] = '{18'h15555, 18'h2AAAA};

   // Wire level from both drivers
   assign data_lane_lower_in = data_lane_lower_oe ? data_lane_lower_out
      : drv[8:0];
   assign data_lane_upper_in = data_lane_upper_oe ? data_lane_upper_out
      : drv[17:9];
   assign q = {data_lane_upper_out, data_lane_lower_out};
   assign q_oe = {data_lane_upper_oe, data_lane_lower_oe};

   fsb_sram fsb_sram_i (.clk, .rstn, .address_upper, .address_bit_one,
      .address_bit_zero, .chip_select_first_n, .chip_select_second,
      .chip_select_third_n, .advance_or_load, .read_not_write,
      .byte_write_lower_n, .byte_write_upper_n, .output_enable_n,
      .clock_hold_n, .burst_order_select_n, .sleep_request,
      .data_lane_lower_in, .data_lane_upper_in, .data_lane_lower_out,
      .data_lane_upper_out, .data_lane_lower_oe, .data_lane_upper_oe);

   fsb_ctl_model ctl_i (.clk, .address_upper, .address_bit_one,
      .address_bit_zero, .chip_select_first_n, .chip_select_second,
      .chip_select_third_n, .advance_or_load, .read_not_write,
      .byte_write_lower_n, .byte_write_upper_n, .output_enable_n,
      .clock_hold_n, .burst_order_select_n, .sleep_request, .drv, .q,
      .q_oe);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input fsb_word_t got, input logic [1:0] goe,
         input logic eoe, input fsb_word_t e);
      total_checks++;
      if (goe !== {eoe, eoe} || (eoe && got !== e)) begin
         fails++;
         $display("MISMATCH %0t oe %b/%b data %h/%h", $time, goe, eoe,
            got, e);
      end
   endtask : chk

   task automatic step(input logic [10:0] c, input fsb_addr_t a,
         input fsb_word_t d, input logic eoe, input fsb_word_t e);
      ctl_i.go(c, a, d);
      chk(ctl_i.q_r, ctl_i.qoe_r, eoe, e);
   endtask : step

   task summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // Bounded run; a hang ends in the report
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      $display("MISMATCH %0t run too long", $time);
      summarize();
   end

   initial begin
      rstn = 1'b0;
      repeat (12) @(posedge clk);
      chk(q, q_oe, 1'b0, 18'h00000); // Floating in reset
      @(negedge clk);
      rstn = 1'b1;
      step(WR, 20'h00012, 18'h00000, 0, 0); // Write load
      for (int i = 0; i < 3; i++) begin
         step(AD | DV, 0, dw[i], 0, 0);
      end
      step(DS | DV, 0, dw[3], 0, 0); // Last beat
      $display("write burst done");
      step(RD | LIN, 20'h00011, 0, 0, 0); // Read load
      for (int i = 0; i < 4; i++) begin
         step(AD | LIN, 0, 0, 1, dw[(i + 3) % 4]);
      end
      step(HLD, 20'h00011, 0, 1, dw[3]); // Wraps to start
      step(AD | OEH | LIN, 0, 0, 1, dw[3]); // Frozen by hold
      step(AD | LIN, 0, 0, 0, 0); // Dummy read floats
      step(DS, 0, 0, 1, dw[1]); // Dummy beat advanced
      step(AD, 0, 0, 0, 0); // Deselect floats
      step(DS, 0, 0, 0, 0); // Continue deselect floats
      $display("read burst done");
      e12 = {dw[0][17:9], nw[0][8:0]};
      e13 = {nw[1][17:9], dw[1][8:0]};
      step(WR | 11'h002, 20'h00012, 0, 0, 0); // Lower lane only
      step(AD | 11'h001 | DV, 0, nw[0], 0, 0); // Upper lane
      step(AD | 11'h003 | DV, 0, nw[1], 0, 0); // Abort beat
      step(DS | DV, 0, nw[0], 0, 0);
      step(RD, 20'h00012, 0, 0, 0);
      step(AD, 0, 0, 1, e12); // Lower lane only
      step(AD, 0, 0, 1, e13); // Upper lane only
      step(DS, 0, 0, 1, dw[2]); // Nothing stored on abort
      $display("byte lanes done");
      for (int k = 1; k < 4; k++) begin
         step(RD, 20'h00012, 0, 0, 0);
         step(RD | (k << 7), 20'h00012, 0, 1, e12);
      end
      $display("selects done");
      // Last write has completed before sleep
      step(RD, 20'h00011, 0, 0, 0);
      step(SLP | RD, 20'h00011, 0, 1, dw[3]);
      #1 chk(q, q_oe, 1'b0, 18'h00000); // Floats at once
      step(SLP | WR, 20'h00011, 0, 0, 0); // Ignored in snooze
      step(SLP | AD | DV, 0, nw[0], 0, 0);
      step(DS, 0, 0, 0, 0); // Only deselect or read on wake
      step(RD, 20'h00011, 0, 0, 0);
      step(DS, 0, 0, 1, dw[3]); // Contents kept
      step(DS, 0, 0, 0, 0);
      $display("snooze done");
      summarize();
   end
endmodule : test_fsb_sram
